// *** rtl/dbgtc_top.sv ***
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
// What this block does
// - The low-byte port returns the low byte of the current trace word.
// - Reading the low-byte port advances the read pointer one word.
// - In event-only modes only the low byte carries content.
// - Extension bit 7 includes bus direction in the match.
// - Extension bit 6 picks write (0) or read (1) cycles.
// - The direction value is ignored while bit 7 is clear.
// - Extension bit 5 must equal the paged-access flag.
// - Paged accesses compare page index joined to address bits 13:0.
// - Non-paged accesses compare a zero-extended or linear address.
// - Extension bit 0 is the expected address bit 16.
// - End-run reset, enable set, start trigger clear: settings kept.
// - The low compare byte gives expected address bits 7:0.
// - The high-byte port returns bits 15:8 without advancing.
module dbgtc_top #(
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  // Register port.
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Trace capture from the rest of the debug module.
  input  wire logic        i_trace_push,
  input  wire logic [23:0] i_trace_word,
  input  wire logic        i_event_only,
  // Debug module controls.
  input  wire logic        i_debug_module_enable,
  input  wire logic        i_trigger_at_start,
  input  wire logic        i_end_run_reset,
  // Core bus being monitored.
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic [16:0] i_linear_addr,
  input  wire logic        i_linear_sel,
  input  wire logic [2:0]  i_page,
  input  wire logic        i_paged,
  input  wire logic        i_read,
  // Results.
  output logic             o_match_a,
  output logic [7:0]       o_level
);

  localparam int PW = $clog2(DEPTH);

  logic [23:0]   mem_q [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [7:0]    count_q;
  logic [7:0]    low_bits_q;
  logic [7:0]    ext_q;
  logic [7:0]    rdata_q;
  logic          keep_q;
  logic [23:0]   cur_word;
  logic          pop;
  logic          push;
  logic          wr_low;
  logic          wr_ext;
  logic [7:0]    rd_mux;

  // Decoding of register accesses.
  assign wr_low   = i_wr && (i_addr == dbgtc_pkg::OFF_CMP_A_LOW);
  assign wr_ext   = i_wr && (i_addr == dbgtc_pkg::OFF_CMP_A_EXT);
  assign pop      = i_rd && (i_addr == dbgtc_pkg::OFF_TRACE_LOW)
                 && (count_q != 8'h00);
  assign push     = i_trace_push && (count_q != 8'(DEPTH));
  assign cur_word = mem_q[rptr_q];

  // Read data selection; event-only words give zero high bytes.
  always_comb begin
    if (i_addr == dbgtc_pkg::OFF_TRACE_LOW) begin
      rd_mux = cur_word[7:0];
    end else if (i_addr == dbgtc_pkg::OFF_TRACE_HIGH) begin
      rd_mux = i_event_only ? 8'h00 : cur_word[15:8];
    end else if (i_addr == dbgtc_pkg::OFF_TRACE_EXT) begin
      rd_mux = i_event_only ? 8'h00 : cur_word[23:16];
    end else if (i_addr == dbgtc_pkg::OFF_CMP_A_LOW) begin
      rd_mux = low_bits_q;
    end else if (i_addr == dbgtc_pkg::OFF_CMP_A_EXT) begin
      rd_mux = ext_q & dbgtc_pkg::EXT_MASK;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Read data registered one cycle after the strobe.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_rd ? rd_mux : 8'h00;
    end
  end
  assign o_rdata = rdata_q;

  // Trace storage; the array has no reset so it maps to memory.
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wptr_q] <= i_trace_word;
    end
  end

  // Pointers and level; the low-byte read moves to the next word.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= 8'h00;
    end else begin
      if (push) begin
        wptr_q <= PW'(wptr_q + 1'b1);
      end
      if (pop) begin
        rptr_q <= PW'(rptr_q + 1'b1);
      end
      count_q <= 8'(count_q + {7'h00, push} - {7'h00, pop});
    end
  end
  assign o_level = count_q;

  // The end-run condition is sampled each clock, so a later reset can
  // tell whether the settings should survive it.
  always_ff @(posedge i_mclk) begin
    keep_q <= i_end_run_reset && i_debug_module_enable
           && !i_trigger_at_start;
  end

  // Settings registers: cleared by the reset pin only when no end-run
  // hold was captured. The hold is a plain sampled bit, not an async
  // load, so the reset value stays constant when it applies.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b && !keep_q) begin
      low_bits_q <= dbgtc_pkg::RST_VALUE;
      ext_q      <= dbgtc_pkg::RST_VALUE;
    end else if (i_rst_b) begin
      if (wr_low) begin
        low_bits_q <= i_wdata;
      end
      if (wr_ext) begin
        ext_q <= i_wdata & dbgtc_pkg::EXT_MASK;
      end
    end
  end

  // Comparator A.
  dbgtc_cmp_a u_cmp_a (
    .i_low_bits    (low_bits_q),
    .i_ext         (ext_q),
    .i_cpu_addr    (i_cpu_addr),
    .i_linear_addr (i_linear_addr),
    .i_linear_sel  (i_linear_sel),
    .i_page        (i_page),
    .i_paged       (i_paged),
    .i_read        (i_read),
    .o_match       (o_match_a)
  );

  // Checks. The read-out steps are named sequences shared by the pointer
  // and data properties below, except the empty-store, low-byte data and event-only high-byte checks.

  // A low-byte read that finds a stored word; it is the only pop.
  sequence s_low_read;
    i_rd && (i_addr == dbgtc_pkg::OFF_TRACE_LOW) && (count_q != 8'h00);
  endsequence

  // A high-byte read; it must leave the pointers where they are.
  sequence s_high_read;
    i_rd && (i_addr == dbgtc_pkg::OFF_TRACE_HIGH);
  endsequence

  // An extension-byte read of the current trace word.
  sequence s_ext_read;
    i_rd && (i_addr == dbgtc_pkg::OFF_TRACE_EXT);
  endsequence

  // A settings write, one slot with no write, then the readback strobe.
  sequence s_ext_write_back;
    wr_ext ##1 !i_wr ##1 (i_rd && (i_addr == dbgtc_pkg::OFF_CMP_A_EXT));
  endsequence

  // The low-byte read moves the read pointer by exactly one word.
  a_low_read_advance: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (s_low_read and !push) |=> rptr_q == PW'($past(rptr_q) + 1'b1))
    else $error("Low-byte read did not advance.");

  // The same read takes one word off the level.
  a_low_read_level: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (s_low_read and !push) |=> count_q == 8'($past(count_q) - 8'h01))
    else $error("Low-byte read did not lower the level.");

  // A capture alone adds one word to the level.
  a_push_level: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    push && !pop |=> count_q == 8'($past(count_q) + 8'h01))
    else $error("Capture did not raise the level.");

  // An empty store must not be popped; the pointer would run past the
  // write pointer and the level would wrap to 8'hff.
  a_empty_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && (i_addr == dbgtc_pkg::OFF_TRACE_LOW) && (count_q == 8'h00)
    |=> $stable(rptr_q))
    else $error("Low-byte read of empty store moved the pointer.");

  // The high byte may be read any number of times.
  a_high_read_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    s_high_read |=> $stable(rptr_q))
    else $error("High-byte read moved the pointer.");

  // Only the low byte advances, so the extension read holds too.
  a_ext_read_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    s_ext_read |=> $stable(rptr_q))
    else $error("Extension-byte read moved the pointer.");

  // Low-byte data are those of the word current at the strobe.
  a_low_byte_data: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && (i_addr == dbgtc_pkg::OFF_TRACE_LOW) |=>
    o_rdata == $past(cur_word[7:0]))
    else $error("Low byte data wrong.");

  // High-byte data are bits 15 to 8 of the current word.
  a_high_byte_data: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (s_high_read and !i_event_only) |=> o_rdata == $past(cur_word[15:8]))
    else $error("High byte data wrong.");

  // Event-only words carry nothing in the high byte.
  a_event_high_zero: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && i_event_only && (i_addr == dbgtc_pkg::OFF_TRACE_HIGH)
    |=> o_rdata == 8'h00)
    else $error("Event-only high byte not zero.");

  // Nor in the extension byte.
  a_event_ext_zero: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (s_ext_read and i_event_only) |=> o_rdata == 8'h00)
    else $error("Event-only extension byte not zero.");

  // Read data stand for one cycle only and are zero otherwise.
  a_rdata_idle: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !i_rd |=> o_rdata == 8'h00)
    else $error("Read data present without a read.");

  // With direction checking on, the other direction never matches.
  a_dir_qualify: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    ext_q[dbgtc_pkg::DIR_EN_BIT] && (i_read != ext_q[dbgtc_pkg::DIR_VAL_BIT])
    |-> !o_match_a)
    else $error("Direction mismatch matched.");

  // With direction checking off, either direction matches.
  a_dir_ignored: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !ext_q[dbgtc_pkg::DIR_EN_BIT] && !ext_q[dbgtc_pkg::PAGE_BIT]
    && !ext_q[dbgtc_pkg::ADDR16_BIT] && !i_paged && !i_linear_sel
    && (i_cpu_addr[7:0] == low_bits_q) |-> o_match_a)
    else $error("Direction value blocked a match.");

  // The paged flag must equal the page select bit.
  a_page_qualify: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_paged != ext_q[dbgtc_pkg::PAGE_BIT]) |-> !o_match_a)
    else $error("Page mismatch matched.");

  // A plain core address has bit 16 at zero.
  a_bit16_qualify: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !i_paged && !i_linear_sel && ext_q[dbgtc_pkg::ADDR16_BIT]
    |-> !o_match_a)
    else $error("Bit 16 mismatch matched.");

  // A match needs the low byte equal, except from the linear source.
  a_low_addr_match: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_match_a |-> i_cpu_addr[7:0] == low_bits_q
    || (i_linear_sel && !i_paged))
    else $error("Low address mismatch matched.");

  // Written settings read back through the writable mask.
  a_ext_write: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    s_ext_write_back
    |=> o_rdata == ($past(i_wdata, 3) & dbgtc_pkg::EXT_MASK))
    else $error("Extension register readback wrong.");

  // An end-run reset leaves the settings alone. These two watch the
  // reset itself, so they carry no disable clause.
  a_keep_settings: assert property (
    @(posedge i_mclk)
    !i_rst_b && keep_q |=> $stable(ext_q) && $stable(low_bits_q))
    else $error("Settings changed across an end-run reset.");

  // Any other reset clears them.
  a_clear_settings: assert property (
    @(posedge i_mclk)
    !i_rst_b && !keep_q |=> (ext_q == dbgtc_pkg::RST_VALUE)
    && (low_bits_q == dbgtc_pkg::RST_VALUE))
    else $error("Settings not cleared by reset.");

endmodule : dbgtc_top

// *** pkg/dbgtc_pkg.sv ***
package dbgtc_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFF_CMP_A_LOW   = 4'h1;
  localparam logic [3:0] OFF_TRACE_HIGH  = 4'h6;
  localparam logic [3:0] OFF_TRACE_LOW   = 4'h7;
  localparam logic [3:0] OFF_CMP_A_EXT   = 4'h8;
  localparam logic [3:0] OFF_TRACE_EXT   = 4'hb;

  // Field positions in the comparator A extension register.
  localparam int DIR_EN_BIT  = 7;
  localparam int DIR_VAL_BIT = 6;
  localparam int PAGE_BIT    = 5;
  localparam int ADDR16_BIT  = 0;

  // Writable bits of the extension register; others read as zero.
  localparam logic [7:0] EXT_MASK  = 8'he1;
  localparam logic [7:0] RST_VALUE = 8'h00;

  // Address layout of the core bus.
  localparam int ADDR_W = 17;
  localparam int PAGE_W = 3;
  localparam int OFFS_W = 14;

  // Trace word layout: extension, high, low bytes.
  localparam int WORD_W = 24;

endpackage : dbgtc_pkg

// *** rtl/dbgtc_cmp_a.sv ***
`timescale 1ns/100ps
// Comparator A: forms the 17-bit core address and qualifies the match.
module dbgtc_cmp_a (
  // Settings.
  input  wire logic [7:0]  i_low_bits,
  input  wire logic [7:0]  i_ext,
  // Core bus.
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic [16:0] i_linear_addr,
  input  wire logic        i_linear_sel,
  input  wire logic [2:0]  i_page,
  input  wire logic        i_paged,
  input  wire logic        i_read,
  // Result.
  output logic             o_match
);

  logic [16:0] core_addr;
  logic        addr_ok;
  logic        dir_ok;
  logic        page_ok;

  // Paged fetches splice the page index over the window offset.
  assign core_addr = i_paged ? {i_page, i_cpu_addr[13:0]}
                   : i_linear_sel ? i_linear_addr
                   : {1'b0, i_cpu_addr};
  // Only bit 16 and the low byte are compared in this block; the middle
  // byte belongs to the high comparator elsewhere.
  assign addr_ok = (core_addr[7:0] == i_low_bits)
                 && (core_addr[16] ==
                     i_ext[dbgtc_pkg::ADDR16_BIT]);
  // The value bit is read only behind the enable bit.
  assign dir_ok  = !i_ext[dbgtc_pkg::DIR_EN_BIT]
                 || (i_read == i_ext[dbgtc_pkg::DIR_VAL_BIT]);
  assign page_ok = (i_paged == i_ext[dbgtc_pkg::PAGE_BIT]);
  assign o_match = addr_ok && dir_ok && page_ok;

endmodule : dbgtc_cmp_a

// *** testbench/dbgtc_bus_model.sv ***
`timescale 1ns/100ps
// Core bus model: one bus cycle per call, driven just after a rising edge.
module dbgtc_bus_model (
  // Clock.
  input  wire logic        i_mclk,
  // Core bus.
  output logic      [15:0] o_cpu_addr,
  output logic      [16:0] o_linear_addr,
  output logic             o_linear_sel,
  output logic      [2:0]  o_page,
  output logic             o_paged,
  output logic             o_read
);
  // The source not in use carries the inverse address, except the linear one when paged and
  // linear are both set. A comparator that picks the wrong source then sees a wrong value instead of a lucky one.
  task automatic cycle(input logic [16:0] a, input logic pg, ls, rd);
    @(posedge i_mclk);
    o_paged       <= pg;
    o_read        <= rd;
    o_linear_sel  <= ls;
    o_page        <= pg ? a[16:14] : ~a[16:14];
    o_cpu_addr    <= (pg || !ls) ? a[15:0] : ~a[15:0];
    o_linear_addr <= ls ? a : ~a;
  endtask : cycle
endmodule : dbgtc_bus_model

// *** testbench/tb.sv ***
`timescale 1ns/100ps
// Bench for the trace read-out port and comparator A.
module tb;
  logic        clk, rst_b, wr, rd, push, evo, en, trg, err;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, level;
  logic [23:0] word;
  logic [15:0] cpu;
  logic [16:0] lin;
  logic [2:0]  page;
  logic        lsel, paged, rdc, match;
  int          fail_count, checks;

  dbgtc_top #(.DEPTH(8)) dut_u (.i_mclk(clk), .i_rst_b(rst_b),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_trace_push(push), .i_trace_word(word), .i_event_only(evo),
    .i_debug_module_enable(en), .i_trigger_at_start(trg),
    .i_end_run_reset(err), .i_cpu_addr(cpu), .i_linear_addr(lin),
    .i_linear_sel(lsel), .i_page(page), .i_paged(paged), .i_read(rdc),
    .o_match_a(match), .o_level(level));

  dbgtc_bus_model bus_u (.i_mclk(clk), .o_cpu_addr(cpu),
    .o_linear_addr(lin), .o_linear_sel(lsel), .o_page(page),
    .o_paged(paged), .o_read(rdc));

  // Free-running clock, 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string n, input logic [23:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e,
                        input string n);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    check(n, {16'h0000, rdata}, {16'h0000, e});
  endtask : rd_reg

  task automatic push_word(input logic [23:0] w);
    @(posedge clk);
    push <= 1'b1;
    word <= w;
    @(posedge clk);
    push <= 1'b0;
  endtask : push_word

  task automatic cmp(input logic [7:0] x, input logic [16:0] a,
                     input logic pg, ls, r, e);
    wr_reg(4'h8, x);
    bus_u.cycle(a, pg, ls, r);
    @(negedge clk);
    check("match", {23'h000000, match}, {23'h000000, e});
  endtask : cmp

  // The end-run flag is set one edge early so the keep decision sees it.
  task automatic do_reset(input logic e, t);
    @(posedge clk);
    en  <= e;
    trg <= t;
    err <= 1'b1;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    err   <= 1'b0;
  endtask : do_reset

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // Main sequence.
  initial begin
    {rst_b, wr, rd, push, evo, en, trg, err} = 8'h00;
    {addr, wdata, word} = 36'h0;
    do_reset(1'b0, 1'b0);
    rd_reg(4'h8, 8'h00, "ext_rst");
    wr_reg(4'h8, 8'hff);
    rd_reg(4'h8, 8'he1, "ext_rw");
    rd_reg(4'hf, 8'h00, "unmapped");
    wr_reg(4'h1, 8'h5a);
    rd_reg(4'h1, 8'h5a, "low_rw");
    for (int i = 0; i < 8; i++) begin
      cmp({i[2:1], 6'h00}, 17'h0005a, 1'b0, 1'b0, i[0],
          !i[2] || (i[1] == i[0]));
    end
    cmp(8'h00, 17'h0005b, 1'b0, 1'b0, 1'b0, 1'b0);
    cmp(8'h21, 17'h1005a, 1'b1, 1'b0, 1'b0, 1'b1);
    cmp(8'h01, 17'h1005a, 1'b1, 1'b0, 1'b0, 1'b0);
    cmp(8'h20, 17'h1005a, 1'b1, 1'b0, 1'b0, 1'b0);
    cmp(8'h01, 17'h1005a, 1'b0, 1'b1, 1'b0, 1'b1);
    cmp(8'h01, 17'h1005a, 1'b0, 1'b0, 1'b0, 1'b0);
    cmp(8'h00, 17'h1005a, 1'b0, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      push_word({8'ha0 + i[7:0], 8'hb0 + i[7:0], 8'hc0 + i[7:0]});
    end
    @(negedge clk);
    check("level", {16'h0000, level}, 24'h000003);
    for (int i = 0; i < 3; i++) begin
      rd_reg(4'hb, 8'ha0 + i[7:0], "ext");
      rd_reg(4'h6, 8'hb0 + i[7:0], "high");
      rd_reg(4'h6, 8'hb0 + i[7:0], "high_again");
      rd_reg(4'h7, 8'hc0 + i[7:0], "low");
    end
    check("level_empty", {16'h0000, level}, 24'h000000);
    @(posedge clk);
    evo <= 1'b1;
    push_word(24'h123456);
    rd_reg(4'h6, 8'h00, "evo_high");
    rd_reg(4'hb, 8'h00, "evo_ext");
    rd_reg(4'h7, 8'h56, "evo_low");
    wr_reg(4'h8, 8'he1);
    do_reset(1'b1, 1'b0);
    rd_reg(4'h8, 8'he1, "ext_keep");
    rd_reg(4'h1, 8'h5a, "low_keep");
    do_reset(1'b1, 1'b1);
    rd_reg(4'h8, 8'h00, "ext_clear");
    final_report();
  end

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #(40 * 4000);
    fail_count++;
    final_report();
  end
endmodule : tb
